/* core/isrt_exec.sv */
/*
 * Executor for the index skip and inter-register transfer instructions,
 * holding the accumulator, auxiliary, index, extension, state and channel
 * index registers, the 64-word register file and the page map file.
 * Assumes the fetch logic presents one instruction word per cycle with
 * instr_valid, and uses skip_next to pick P+1 or P+2.
 */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "isrt_defs.svh"

module isrt_exec
    import isrt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instr_valid,
    input  wire logic [23:0] instr_word,
    input  wire logic        io_instr,
    input  wire logic [2:0]  chan_desig,
    output logic             exec_done,
    output logic             skip_next,
    output logic             claimed,
    output logic             shift_op_seen,
    output logic      [2:0]  chan_eff
);

    function automatic isrt_word_type oc_add24(input isrt_word_type x, input isrt_word_type y);
        logic [24:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[23:0] + {23'h000000, s[24]};
    endfunction : oc_add24

    function automatic isrt_index_type oc_add15(input isrt_index_type x, input isrt_index_type y);
        logic [15:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[14:0] + {14'h0000, s[15]};
    endfunction : oc_add15

    function automatic isrt_word_type sx15(input isrt_index_type x);
        return {{9{x[14]}}, x};
    endfunction : sx15

    isrt_word_type  a_r;
    isrt_word_type  q_r;
    isrt_word_type  eu_r;
    isrt_word_type  el_r;
    isrt_index_type bx_r    [0:3];
    isrt_small_type isr_r;
    isrt_small_type osr_r;
    isrt_small_type cir_r;
    logic           mp_en_r;
    logic           skip_r;
    logic           shift_r;
    logic           claim_r;
    logic           done_r;
    logic [2:0]     chan_r;
    logic [31:0]    prdata_r;
    logic           rdy_r;
    logic           err_r;
    isrt_word_type  rfile   [0:63];
    isrt_page_type  pfile   [0:127];

    isrt_word_type  a_nxt;
    isrt_word_type  q_nxt;
    isrt_word_type  eu_nxt;
    isrt_word_type  el_nxt;
    isrt_index_type b_nxt;
    logic           b_we;
    isrt_small_type isr_nxt;
    isrt_small_type osr_nxt;
    isrt_small_type cir_nxt;
    logic           skip_nxt;
    logic           shift_nxt;
    logic           claim_nxt;
    logic           rf_we;
    isrt_word_type  rf_wdata;
    logic           pf_we;
    logic [6:0]     pf_addr;

    logic [5:0]     op;
    logic [1:0]     bsel;
    logic [2:0]     sub;
    logic [5:0]     fn;
    logic [2:0]     low;
    logic [5:0]     vsel;
    isrt_index_type yval;
    isrt_index_type bval;
    isrt_word_type  rf_rd;
    logic           apb_done;
    logic           apb_wr;
    logic           map_hit;
    logic [31:0]    rd_mux;

    assign op      = instr_word[23:18];
    assign bsel    = instr_word[16:15];
    assign sub     = instr_word[14:12];
    assign fn      = instr_word[17:12];
    assign low     = instr_word[11:9];
    assign vsel    = instr_word[5:0];
    assign yval    = instr_word[14:0];
    assign bval    = bx_r[bsel];
    assign rf_rd   = rfile[vsel];
    // Bit 11 offsets the page entry by index 2
    assign pf_addr = instr_word[11] ? (instr_word[6:0] + bx_r[2][6:0])
                                    : instr_word[6:0];

    // Execution of one instruction word per cycle; field bits outside the
    // decoded ones are not examined.
    always_comb
    begin
        a_nxt     = a_r;
        q_nxt     = q_r;
        eu_nxt    = eu_r;
        el_nxt    = el_r;
        b_nxt     = bval;
        b_we      = 1'b0;
        isr_nxt   = isr_r;
        osr_nxt   = osr_r;
        cir_nxt   = cir_r;
        skip_nxt  = 1'b0;
        shift_nxt = 1'b0;
        claim_nxt = 1'b0;
        rf_we     = 1'b0;
        rf_wdata  = `ISRT_RST_WORD;
        pf_we     = 1'b0;
        if (instr_valid)
        begin
            case (op)
                `ISRT_OP_SKIP:
                begin
                    if (instr_word[17:15] == 3'h0)
                    begin
                        shift_nxt = 1'b1;
                    end
                    else
                    begin
                        claim_nxt = 1'b1;
                        skip_nxt  = (bval == yval);
                        b_we      = (bsel != 2'h0);
                        if (bval == yval)
                            b_nxt = `ISRT_RST_IDX;
                        else if (instr_word[17])
                            b_nxt = oc_add15(bval, `ISRT_IDX_MINUS1);
                        else
                            b_nxt = oc_add15(bval, 15'h0001);
                    end
                end
                `ISRT_OP_XFER:
                begin
                    claim_nxt = 1'b1;
                    case (sub)
                        `ISRT_SUB_ADD:
                        begin
                            if (instr_word[17])
                            begin
                                b_we  = (bsel != 2'h0);
                                b_nxt = 15'(oc_add24(sx15(bval), a_r));
                            end
                            else if (bsel == 2'h0)
                                a_nxt = oc_add24(a_r, q_r);
                            else
                                a_nxt = oc_add24(a_r, sx15(bval));
                        end
                        `ISRT_SUB_IDX:
                        begin
                            if (instr_word[17])
                            begin
                                b_we  = (bsel != 2'h0);
                                b_nxt = a_r[14:0];
                            end
                            else
                                a_nxt = {9'h000, bval};
                        end
                        `ISRT_SUB_AUXF:
                        begin
                            if (instr_word[17])
                            begin
                                rf_we    = 1'b1;
                                rf_wdata = q_r;
                            end
                            else
                                q_nxt = rf_rd;
                        end
                        `ISRT_SUB_ACCF:
                        begin
                            if (instr_word[17])
                            begin
                                rf_we    = 1'b1;
                                rf_wdata = a_r;
                            end
                            else
                                a_nxt = rf_rd;
                        end
                        `ISRT_SUB_IDXF:
                        begin
                            if (instr_word[17])
                            begin
                                rf_we    = 1'b1;
                                rf_wdata = {9'h000, bval};
                            end
                            else
                            begin
                                b_we  = (bsel != 2'h0);
                                b_nxt = rf_rd[14:0];
                            end
                        end
                        default:
                            claim_nxt = 1'b0;
                    endcase
                end
                `ISRT_OP_EXT:
                begin
                    claim_nxt = 1'b1;
                    case (instr_word[17:15])
                        `ISRT_EXT_LO_AUX:   q_nxt = el_r;
                        `ISRT_EXT_HI_ACC:   a_nxt = eu_r;
                        `ISRT_EXT_PAIR_IN:
                        begin
                            a_nxt = eu_r;
                            q_nxt = el_r;
                        end
                        `ISRT_EXT_AUX_LO:   el_nxt = q_r;
                        `ISRT_EXT_ACC_HI:   eu_nxt = a_r;
                        `ISRT_EXT_PAIR_OUT:
                        begin
                            eu_nxt = a_r;
                            el_nxt = q_r;
                        end
                        default:            claim_nxt = 1'b0;
                    endcase
                end
                `ISRT_OP_SYS:
                begin
                    claim_nxt = 1'b1;
                    case (fn)
                        `ISRT_FN_TO_STATE:
                        begin
                            if (low == `ISRT_LOW_INSTR)
                                isr_nxt = a_r[2:0];
                            else
                                osr_nxt = a_r[2:0];
                        end
                        `ISRT_FN_FROM_ST:
                        begin
                            if (low == `ISRT_LOW_INSTR)
                                a_nxt = {a_r[23:3], isr_r};
                            else
                                a_nxt = {a_r[23:3], osr_r};
                        end
                        `ISRT_FN_ACI:       cir_nxt = a_r[2:0];
                        `ISRT_FN_CIA:       a_nxt = {a_r[23:3], cir_r};
                        `ISRT_FN_APF:       pf_we = mp_en_r;
                        `ISRT_FN_PFA:       a_nxt = {a_r[23:12], pfile[pf_addr]};
                        default:            claim_nxt = 1'b0;
                    endcase
                end
                default:
                    claim_nxt = 1'b0;
            endcase
        end
    end

    // APB slave; one wait state, and the bus stalls while an instruction runs
    assign apb_done = psel && penable && pready;
    assign apb_wr   = apb_done && pwrite;
    assign pready   = rdy_r && !instr_valid;
    assign prdata   = prdata_r;
    assign pslverr  = err_r && pready;

    always_comb
    begin
        map_hit = 1'b1;
        rd_mux  = 32'h00000000;
        case (paddr)
            `ISRT_OFF_ACC:    rd_mux = {8'h00, a_r};
            `ISRT_OFF_AUX:    rd_mux = {8'h00, q_r};
            `ISRT_OFF_IDX1:   rd_mux = {17'h00000, bx_r[1]};
            `ISRT_OFF_IDX2:   rd_mux = {17'h00000, bx_r[2]};
            `ISRT_OFF_IDX3:   rd_mux = {17'h00000, bx_r[3]};
            `ISRT_OFF_EXTH:   rd_mux = {8'h00, eu_r};
            `ISRT_OFF_EXTL:   rd_mux = {8'h00, el_r};
            `ISRT_OFF_STATE:  rd_mux = {23'h000000, cir_r, osr_r, isr_r};
            `ISRT_OFF_CTRL:   rd_mux = {31'h00000000, mp_en_r};
            `ISRT_OFF_STATUS: rd_mux = {29'h00000000, claim_r, shift_r, skip_r};
            default:          map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_r    <= 1'b0;
            err_r    <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else if (apb_done || instr_valid)
            rdy_r <= 1'b0;
        else if (psel && penable)
        begin
            rdy_r    <= 1'b1;
            err_r    <= !map_hit;
            prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_r <= `ISRT_RST_WORD;
            q_r <= `ISRT_RST_WORD;
        end
        else if (apb_wr && paddr == `ISRT_OFF_ACC)
            a_r <= pwdata[23:0];
        else if (apb_wr && paddr == `ISRT_OFF_AUX)
            q_r <= pwdata[23:0];
        else
        begin
            a_r <= a_nxt;
            q_r <= q_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eu_r <= `ISRT_RST_WORD;
            el_r <= `ISRT_RST_WORD;
        end
        else if (apb_wr && paddr == `ISRT_OFF_EXTH)
            eu_r <= pwdata[23:0];
        else if (apb_wr && paddr == `ISRT_OFF_EXTL)
            el_r <= pwdata[23:0];
        else
        begin
            eu_r <= eu_nxt;
            el_r <= el_nxt;
        end
    end

    // Entry 0 stays zero so that designator 0 reads as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                bx_r[i] <= `ISRT_RST_IDX;
        end
        else if (apb_wr && paddr == `ISRT_OFF_IDX1)
            bx_r[1] <= pwdata[14:0];
        else if (apb_wr && paddr == `ISRT_OFF_IDX2)
            bx_r[2] <= pwdata[14:0];
        else if (apb_wr && paddr == `ISRT_OFF_IDX3)
            bx_r[3] <= pwdata[14:0];
        else if (b_we)
            bx_r[bsel] <= b_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            isr_r   <= `ISRT_RST_SMALL;
            osr_r   <= `ISRT_RST_SMALL;
            cir_r   <= `ISRT_RST_SMALL;
            mp_en_r <= 1'b0;
        end
        else if (apb_wr && paddr == `ISRT_OFF_STATE)
        begin
            isr_r <= pwdata[2:0];
            osr_r <= pwdata[5:3];
            cir_r <= pwdata[8:6];
        end
        else if (apb_wr && paddr == `ISRT_OFF_CTRL)
            mp_en_r <= pwdata[0];
        else
        begin
            isr_r <= isr_nxt;
            osr_r <= osr_nxt;
            cir_r <= cir_nxt;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (rf_we)
            rfile[vsel] <= rf_wdata;
        if (pf_we)
            pfile[pf_addr] <= a_r[11:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_r  <= 1'b0;
            skip_r  <= 1'b0;
            shift_r <= 1'b0;
            claim_r <= 1'b0;
        end
        else
        begin
            done_r <= instr_valid;
            if (instr_valid)
            begin
                skip_r  <= skip_nxt;
                shift_r <= shift_nxt;
                claim_r <= claim_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chan_r <= 3'h0;
        else
            chan_r <= io_instr ? (chan_desig | cir_r) : chan_desig;
    end

    assign exec_done     = done_r;
    assign skip_next     = skip_r;
    assign claimed       = claim_r;
    assign shift_op_seen = shift_r && done_r;
    assign chan_eff      = chan_r;

    up_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_SKIP && instr_word[17:15] != 3'h0 && bval == yval
        |=> skip_next && exec_done && bx_r[$past(bsel)] == `ISRT_RST_IDX)
        else $error("equal index skip did not clear and skip");

    down_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_SKIP && instr_word[17] && bsel != 2'h0
        && bval != yval
        |=> !skip_next && bx_r[$past(bsel)] == oc_add15($past(bval), `ISRT_IDX_MINUS1))
        else $error("down skip did not decrement the index");

    down_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_SKIP && instr_word[17:15] == 3'h4
        |=> skip_next == ($past(yval) == 15'h0000))
        else $error("down skip on index zero chose the wrong exit");

    shift_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_SKIP && instr_word[17:15] == 3'h0 && !apb_wr
        |=> shift_op_seen && !claimed && !skip_next && $stable(bx_r[1]) && $stable(bx_r[3]))
        else $error("storage shift decoded as an index skip");

    aux_add_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_XFER && sub == `ISRT_SUB_ADD && !instr_word[17]
        && bsel == 2'h0
        |=> $stable(q_r) && a_r == oc_add24($past(a_r), $past(q_r)))
        else $error("accumulator plus auxiliary sum wrong");

    idx_to_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_XFER && sub == `ISRT_SUB_IDX && !instr_word[17]
        |=> a_r[23:15] == 9'h000 && a_r[14:0] == $past(bval))
        else $error("index to accumulator not zero extended");

    file_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_XFER && sub == `ISRT_SUB_IDXF && !instr_word[17]
        && bsel != 2'h0
        |=> bx_r[$past(bsel)] == $past(rf_rd[14:0]))
        else $error("file to index did not take low bits");

    chan_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid && op == `ISRT_OP_SYS && fn == `ISRT_FN_ACI
        |=> cir_r == $past(a_r[2:0]) ##1 (!$past(io_instr) || chan_eff >= $past(cir_r)))
        else $error("channel index not loaded from accumulator");

    chan_or_a: assert property (@(posedge pclk) disable iff (!presetn)
        io_instr |=> chan_eff == ($past(chan_desig) | $past(cir_r)))
        else $error("channel index not merged into designator");

    apb_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_valid |-> !pready)
        else $error("bus answered while an instruction ran");

endmodule : isrt_exec

/* core/isrt_defs.svh */
/*
 * Constants for the index skip and inter-register transfer executor:
 * opcodes, subfield codes, register offsets and reset values.
 * Assumes it is included by bare name from the core files.
 */
`ifndef ISRT_DEFS_SVH
`define ISRT_DEFS_SVH

`define ISRT_OP_SKIP      6'h08
`define ISRT_OP_XFER      6'h2b
`define ISRT_OP_EXT       6'h2d
`define ISRT_OP_SYS       6'h3f

`define ISRT_SUB_ADD      3'h4
`define ISRT_SUB_IDX      3'h5
`define ISRT_SUB_AUXF     3'h0
`define ISRT_SUB_ACCF     3'h2
`define ISRT_SUB_IDXF     3'h3

`define ISRT_EXT_LO_AUX   3'h0
`define ISRT_EXT_HI_ACC   3'h1
`define ISRT_EXT_PAIR_IN  3'h2
`define ISRT_EXT_AUX_LO   3'h4
`define ISRT_EXT_ACC_HI   3'h5
`define ISRT_EXT_PAIR_OUT 3'h6

`define ISRT_FN_APF       6'h34
`define ISRT_FN_PFA       6'h35
`define ISRT_FN_TO_STATE  6'h36
`define ISRT_FN_FROM_ST   6'h37
`define ISRT_FN_ACI       6'h2c
`define ISRT_FN_CIA       6'h2b
`define ISRT_LOW_INSTR    3'h4
`define ISRT_LOW_OPER     3'h0

`define ISRT_OFF_ACC      8'h00
`define ISRT_OFF_AUX      8'h04
`define ISRT_OFF_IDX1     8'h08
`define ISRT_OFF_IDX2     8'h0c
`define ISRT_OFF_IDX3     8'h10
`define ISRT_OFF_EXTH     8'h14
`define ISRT_OFF_EXTL     8'h18
`define ISRT_OFF_STATE    8'h1c
`define ISRT_OFF_CTRL     8'h20
`define ISRT_OFF_STATUS   8'h24

`define ISRT_RST_WORD     24'h000000
`define ISRT_RST_IDX      15'h0000
`define ISRT_RST_SMALL    3'h0
`define ISRT_IDX_MINUS1   15'h7ffe

`endif

/* core/isrt_pkg.sv */
/*
 * Types shared by the index skip and register transfer executor.
 * Assumes nothing of its surroundings.
 */
package isrt_pkg;
    typedef logic [23:0] isrt_word_type;
    typedef logic [14:0] isrt_index_type;
    typedef logic [11:0] isrt_page_type;
    typedef logic [2:0]  isrt_small_type;
endpackage : isrt_pkg

/* tb/isrt_fetch_model.sv */
/* Fetch model: presents one bench word per issue and steps P by skip_next.
   Assumes the bench drives issue and next_word just after a rising edge. */
`timescale 1ns/10ps
module isrt_fetch_model
    import isrt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        issue,
    input  wire logic [23:0] next_word,
    input  wire logic        exec_done,
    input  wire logic        skip_next,
    output logic             instr_valid,
    output logic      [23:0] instr_word,
    output logic      [14:0] pc_r
);
    assign instr_valid = issue;
    // Words carry zeros in unused fields; stale words are inverted
    assign instr_word = issue ? next_word : ~next_word;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_r <= 15'h0000;
        else if (exec_done)
            pc_r <= pc_r + (skip_next ? 15'h0002 : 15'h0001);
    end
endmodule : isrt_fetch_model

/* tb/index_skip_and_register_transfer_bench.sv */
/* Bench for isrt_exec: skip table, random transfers, state and page corners.
   Assumes isrt_fetch_model as the fetch side and APB for register access. */
`timescale 1ns/10ps
`include "isrt_defs.svh"
module index_skip_and_register_transfer_bench
    import isrt_pkg::*;
;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        issue = 1'h0, io_instr = 1'h0, pready, pslverr, err, sh, cl;
    logic        instr_valid, exec_done, skip_next, claimed, shift_op_seen;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] next_word = 24'h0, instr_word;
    logic [2:0]  chan_desig = 3'h0, chan_eff;
    logic [14:0] pc_r, pc0;
    logic [55:0] e;
    logic [55:0] sk [6] = '{56'h0005_0005_1_1_0000, 56'h0005_0007_1_0_0006,
        56'h0009_0009_5_1_0000, 56'h0009_0002_5_0_0008, 56'h0009_0000_4_1_0009,
        56'h0009_0003_4_0_0009};
    int          fails = 0, tests_run = 0, seed = 32'h7a08, n, i;
    isrt_word_type  a, q;
    isrt_index_type x;

    isrt_exec isrt_exec_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instr_valid, .instr_word, .io_instr, .chan_desig,
        .exec_done, .skip_next, .claimed, .shift_op_seen, .chan_eff);
    isrt_fetch_model isrt_fetch_model_i (.pclk, .presetn, .issue, .next_word, .exec_done,
        .skip_next, .instr_valid, .instr_word, .pc_r);

    always #4 pclk = ~pclk;

    // One's complement sum with end-around carry
    function automatic isrt_word_type oadd(isrt_word_type u, isrt_word_type v);
        logic [24:0] s;
        s = u + v;
        return s[23:0] + s[24];
    endfunction : oadd

    function automatic isrt_word_type sx(isrt_index_type v);
        return {{9{v[14]}}, v};
    endfunction : sx

    task automatic complete_run();
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(string nm, logic [31:0] ex_v, logic [31:0] got);
        tests_run++;
        if (got !== ex_v)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex_v, got);
            fails++;
        end
    endtask : chk

    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(negedge pclk);
        for (n = 0; n < 20 && pready !== 1'h1; n++)
            @(negedge pclk);
        if (n == 20)
        begin
            chk("pready", 1, 0);
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic rc(string nm, logic [7:0] ad, logic [31:0] ex_v);
        apb(1'h0, ad, 32'h0);
        chk(nm, ex_v, rd);
    endtask : rc

    task automatic ex(logic [23:0] w);
        issue <= 1'h1;
        next_word <= w;
        @(posedge pclk);
        issue <= 1'h0;
        @(negedge pclk);
        sh = shift_op_seen;
        cl = claimed;
        chk("exec_done", 1, exec_done);
        @(posedge pclk);
    endtask : ex

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (i = 0; i < 10; i++)
            rc("reset", 8'(i * 4), 0);
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped", 1, err);
        for (i = 0; i < 6; i++)
        begin
            e = sk[i];
            apb(1'h1, `ISRT_OFF_IDX1, e[55:40]);
            pc0 = pc_r;
            ex({`ISRT_OP_SKIP, e[22:20], e[38:24]});
            chk("skip_next", e[16], skip_next);
            chk("claimed", 1, cl);
            rc("index", `ISRT_OFF_IDX1, e[15:0]);
            chk("pc", pc0 + 15'h1 + e[16], pc_r);
        end
        ex({`ISRT_OP_SKIP, 3'h0, 15'h0003});
        chk("shift_op", 1, sh);
        chk("claimed", 0, cl);
        ex({6'h01, 18'h00000});
        chk("claimed", 0, cl);
        for (i = 0; i < 8; i++)
        begin
            a = 24'($random(seed));
            q = 24'($random(seed));
            x = 15'($random(seed));
            apb(1'h1, `ISRT_OFF_ACC, a);
            apb(1'h1, `ISRT_OFF_AUX, q);
            apb(1'h1, `ISRT_OFF_IDX1, x);
            ex({`ISRT_OP_XFER, 3'h0, 3'h4, 12'h000});
            chk("claimed", 1, cl);
            ex({`ISRT_OP_XFER, 3'h1, 3'h4, 12'h000});
            a = oadd(oadd(a, q), sx(x));
            rc("acc", `ISRT_OFF_ACC, a);
            rc("aux", `ISRT_OFF_AUX, q);
            ex({`ISRT_OP_XFER, 3'h5, 3'h4, 12'h000});
            x = 15'(oadd(sx(x), a));
            rc("index", `ISRT_OFF_IDX1, x);
            ex({`ISRT_OP_XFER, 3'h4, 3'h2, 6'h00, 6'(i * 9)});
            ex({`ISRT_OP_XFER, 3'h0, 3'h0, 6'h00, 6'(i * 9)});
            rc("file", `ISRT_OFF_AUX, a);
            ex({`ISRT_OP_XFER, 3'h5, 3'h3, 6'h00, 6'(i * 9)});
            ex({`ISRT_OP_XFER, 3'h2, 3'h3, 6'h00, 6'(i * 9)});
            ex({`ISRT_OP_XFER, 3'h0, 3'h2, 6'h00, 6'(i * 9)});
            rc("idx2", `ISRT_OFF_IDX2, x);
            rc("file", `ISRT_OFF_ACC, {9'h0, x});
            ex({`ISRT_OP_EXT, `ISRT_EXT_PAIR_OUT, 15'h0});
            rc("ext", `ISRT_OFF_EXTL, a);
            ex({`ISRT_OP_XFER, 3'h0, 3'h5, 12'h000});
            rc("acc", `ISRT_OFF_ACC, 0);
            ex({`ISRT_OP_EXT, `ISRT_EXT_HI_ACC, 15'h0});
            rc("ext", `ISRT_OFF_ACC, {9'h0, x});
            ex({`ISRT_OP_XFER, 3'h7, 3'h5, 12'h000});
            rc("idx3", `ISRT_OFF_IDX3, x);
        end
        apb(1'h1, `ISRT_OFF_EXTL, 32'h5a5a5a);
        ex({`ISRT_OP_EXT, `ISRT_EXT_PAIR_IN, 15'h0});
        rc("ext", `ISRT_OFF_AUX, 32'h5a5a5a);
        apb(1'h1, `ISRT_OFF_ACC, 32'h00000d);
        ex({`ISRT_OP_SYS, `ISRT_FN_ACI, 12'h000});
        apb(1'h1, `ISRT_OFF_ACC, 32'h000003);
        ex({`ISRT_OP_SYS, `ISRT_FN_TO_STATE, `ISRT_LOW_INSTR, 9'h0});
        apb(1'h1, `ISRT_OFF_ACC, 32'h000006);
        ex({`ISRT_OP_SYS, `ISRT_FN_TO_STATE, `ISRT_LOW_OPER, 9'h0});
        rc("state", `ISRT_OFF_STATE, 32'h173);
        apb(1'h1, `ISRT_OFF_ACC, 32'hfffff8);
        ex({`ISRT_OP_SYS, `ISRT_FN_FROM_ST, `ISRT_LOW_INSTR, 9'h0});
        rc("isr", `ISRT_OFF_ACC, 32'hfffffb);
        ex({`ISRT_OP_SYS, `ISRT_FN_FROM_ST, `ISRT_LOW_OPER, 9'h0});
        rc("osr", `ISRT_OFF_ACC, 32'hfffffe);
        ex({`ISRT_OP_SYS, `ISRT_FN_CIA, 12'h000});
        rc("cir", `ISRT_OFF_ACC, 32'hfffffd);
        io_instr <= 1'h1;
        chan_desig <= 3'h2;
        @(posedge pclk);
        io_instr <= 1'h0;
        @(negedge pclk);
        chk("chan_eff", 3'h7, chan_eff);
        @(negedge pclk);
        chk("chan_eff", 3'h2, chan_eff);
        @(posedge pclk);
        apb(1'h1, `ISRT_OFF_CTRL, 32'h1);
        apb(1'h1, `ISRT_OFF_ACC, 32'h123abc);
        ex({`ISRT_OP_SYS, `ISRT_FN_APF, 12'h005});
        apb(1'h1, `ISRT_OFF_IDX2, 32'h3);
        apb(1'h1, `ISRT_OFF_ACC, 32'h000456);
        ex({`ISRT_OP_SYS, `ISRT_FN_APF, 12'h802});
        apb(1'h1, `ISRT_OFF_CTRL, 32'h0);
        apb(1'h1, `ISRT_OFF_ACC, 32'h000789);
        ex({`ISRT_OP_SYS, `ISRT_FN_APF, 12'h005});
        ex({`ISRT_OP_SYS, `ISRT_FN_PFA, 12'h005});
        rc("page", `ISRT_OFF_ACC, 32'h000456);
        complete_run();
    end
endmodule : index_skip_and_register_transfer_bench
